/* include/pipc_pkg.sv */
// Package: offsets, field layout and reset values of the ingress policing bank
package pipc_pkg;

   // ****************************************************************
   // Register offsets
   // ****************************************************************
   localparam logic [11:0] ADDR_AUTH_CTL = 12'h803;
   localparam logic [11:0] ADDR_POINTER = 12'h804;
   localparam logic [11:0] ADDR_PRIO_MAP = 12'h808;
   localparam logic [11:0] ADDR_POLICE_CTL = 12'h80C;
   localparam logic [11:0] ADDR_QUEUE_RATE = 12'h820;
   localparam logic [11:0] ADDR_QUEUE_BURST = 12'h824;
   localparam logic [11:0] ADDR_PM_THRESH = 12'h830;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int ACL_EN_BIT = 2;
   localparam int PORT_IDX_LSB = 16;
   localparam int QUEUE_PTR_LSB = 0;
   localparam int MAP_FIELD_W = 4;
   localparam int UPPER_LSB = 16;
   localparam int PM_MAX_LSB = 16;
   localparam int PM_THR_W = 11;

   // ****************************************************************
   // Authentication modes
   // ****************************************************************
   localparam logic [1:0] AUTH_RSVD = 2'h0;
   localparam logic [1:0] AUTH_BLOCK = 2'h1;
   localparam logic [1:0] AUTH_PASS = 2'h2;
   localparam logic [1:0] AUTH_TRAP = 2'h3;

   // ****************************************************************
   // Packed police control, bits 11:0 of its register
   // ****************************************************************
   typedef struct packed {
      logic count_drops_only;    // 11
      logic pm_drop_all;         // 10
      logic [1:0] monitor_type;  // 9:8
      logic port_based;          // 7
      logic [1:0] non_ip_frame_colour; // 6:5
      logic colour_mark_en;      // 4
      logic colour_remap_en;     // 3
      logic srp_drop_allow;      // 2
      logic colour_blind;        // 1
      logic police_en;           // 0
   } pipc_police_ctl_t;

   // Per port and queue policer settings
   typedef struct packed {
      logic [15:0] committed_rate;
      logic [15:0] peak_rate;
      logic [15:0] committed_burst;
      logic [15:0] peak_burst;
   } pipc_policer_t;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [1:0] RST_AUTH_MODE = 2'h0;
   localparam logic [31:0] RST_PRIO_MAP = 32'h3322_1100;
   localparam logic [11:0] RST_POLICE_CTL = 12'h020;
   localparam logic [15:0] RST_CIR = 16'h1000;
   localparam logic [15:0] RST_PIR = 16'h2000;
   localparam logic [15:0] RST_CBS = 16'h1000;
   localparam logic [15:0] RST_PBS = 16'h3000;
   localparam logic [10:0] RST_PM_MAX = 11'h400;
   localparam logic [10:0] RST_PM_MIN = 11'h080;

endpackage

/* rtl/pipc_port_ingress.sv */
// Module: per-port ingress policing configuration register bank
module pipc_port_ingress #(
   parameter int NUM_PORTS = 7,
   parameter int NUM_QUEUES = 4
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Register port
   input wire logic [11:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [31:0] reg_wdata_i,
   output logic [31:0] reg_rdata_o,
   output logic reg_rvalid_o,
   // ACL enable from the classifier
   input wire logic acl_enable_i,
   // Authentication decode
   output logic auth_enable_o,
   output logic trap_to_host_o,
   output logic acl_miss_block_o,
   output logic acl_miss_forward_o,
   // Queue regeneration, two bits per priority
   output logic [15:0] prio_queue_o,
   // Police control and derived controls
   output pipc_pkg::pipc_police_ctl_t police_ctl_o,
   output logic wred_active_o,
   output logic srp_drop_allowed_o,
   output logic [2:0] monitor_port_o,
   output logic [1:0] monitor_queue_o,
   // Policer lookup from the datapath
   input wire logic [2:0] pol_port_i,
   input wire logic [1:0] pol_queue_i,
   output pipc_pkg::pipc_policer_t pol_cfg_o,
   // Packet memory drop thresholds
   output logic [10:0] pm_max_thresh_o,
   output logic [10:0] pm_min_thresh_o
);

   localparam int DEPTH = NUM_PORTS * NUM_QUEUES;

   // ****************************************************************
   // Reset release
   // ****************************************************************
   logic rst_meta_ff;
   logic rst_sync_ff;

   // Assert at once, release after two edges
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end
      else
      begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end

   wire rst_n = rst_sync_ff;

   // ****************************************************************
   // Direct registers
   // ****************************************************************
   logic [1:0] auth_mode_ff;
   logic [1:0] nxt_auth_mode;
   logic [2:0] port_idx_ff;
   logic [2:0] nxt_port_idx;
   logic [1:0] queue_ptr_ff;
   logic [1:0] nxt_queue_ptr;
   logic [15:0] map_ff;
   logic [15:0] nxt_map;
   pipc_pkg::pipc_police_ctl_t ctl_ff;
   pipc_pkg::pipc_police_ctl_t nxt_ctl;
   logic [10:0] pm_max_ff;
   logic [10:0] nxt_pm_max;
   logic [10:0] pm_min_ff;
   logic [10:0] nxt_pm_min;

   // Decode writes; reserved bits are simply not stored
   always_comb
   begin
      nxt_auth_mode = auth_mode_ff;
      nxt_port_idx = port_idx_ff;
      nxt_queue_ptr = queue_ptr_ff;
      nxt_map = map_ff;
      nxt_ctl = ctl_ff;
      nxt_pm_max = pm_max_ff;
      nxt_pm_min = pm_min_ff;
      if (reg_wr_i)
      begin
         case (reg_addr_i)
            pipc_pkg::ADDR_AUTH_CTL:
               nxt_auth_mode = reg_wdata_i[1:0];
            pipc_pkg::ADDR_POINTER:
            begin
               nxt_port_idx = reg_wdata_i[pipc_pkg::PORT_IDX_LSB +: 3];
               nxt_queue_ptr = reg_wdata_i[pipc_pkg::QUEUE_PTR_LSB +: 2];
            end
            pipc_pkg::ADDR_PRIO_MAP:
               for (int p = 0; p < 8; p++)
                  nxt_map[2*p +: 2] =
                     reg_wdata_i[pipc_pkg::MAP_FIELD_W*p +: 2];
            pipc_pkg::ADDR_POLICE_CTL:
               nxt_ctl = reg_wdata_i[11:0];
            pipc_pkg::ADDR_PM_THRESH:
            begin
               nxt_pm_max = reg_wdata_i[pipc_pkg::PM_MAX_LSB +: 11];
               nxt_pm_min = reg_wdata_i[10:0];
            end
            default:
               nxt_auth_mode = auth_mode_ff;
         endcase
      end
   end

   // Map reset keeps only the two queue bits of each field
   function automatic logic [15:0] pack_map(input logic [31:0] m);
      logic [15:0] r;
      r = '0;
      for (int p = 0; p < 8; p++)
         r[2*p +: 2] = m[pipc_pkg::MAP_FIELD_W*p +: 2];
      return r;
   endfunction

   // State registers
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         auth_mode_ff <= pipc_pkg::RST_AUTH_MODE;
         port_idx_ff <= 3'h0;
         queue_ptr_ff <= 2'h0;
         map_ff <= pack_map(pipc_pkg::RST_PRIO_MAP);
         ctl_ff <= pipc_pkg::RST_POLICE_CTL;
         pm_max_ff <= pipc_pkg::RST_PM_MAX;
         pm_min_ff <= pipc_pkg::RST_PM_MIN;
      end
      else
      begin
         auth_mode_ff <= nxt_auth_mode;
         port_idx_ff <= nxt_port_idx;
         queue_ptr_ff <= nxt_queue_ptr;
         map_ff <= nxt_map;
         ctl_ff <= nxt_ctl;
         pm_max_ff <= nxt_pm_max;
         pm_min_ff <= nxt_pm_min;
      end
   end

   // ****************************************************************
   // Indirect policer table
   // ****************************************************************
   pipc_pkg::pipc_policer_t pol_mem [DEPTH];
   logic ind_valid;
   logic [4:0] ind_idx;
   logic rate_we;
   logic burst_we;

   // Pointer at the access cycle picks the entry; index 7 is empty
   always_comb
   begin
      ind_valid = (32'(port_idx_ff) < NUM_PORTS);
      ind_idx = {port_idx_ff, queue_ptr_ff};
      rate_we = reg_wr_i && ind_valid &&
                (reg_addr_i == pipc_pkg::ADDR_QUEUE_RATE);
      burst_we = reg_wr_i && ind_valid &&
                 (reg_addr_i == pipc_pkg::ADDR_QUEUE_BURST);
   end

   // Table storage, all entries to documented defaults
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < DEPTH; i++)
            pol_mem[i] <= {pipc_pkg::RST_CIR, pipc_pkg::RST_PIR,
                           pipc_pkg::RST_CBS, pipc_pkg::RST_PBS};
      end
      else
      begin
         if (rate_we)
            pol_mem[ind_idx][63:32] <= reg_wdata_i;
         if (burst_we)
            pol_mem[ind_idx][31:0] <= reg_wdata_i;
      end
   end

   // ****************************************************************
   // Read path
   // ****************************************************************
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic rvalid_ff;
   pipc_pkg::pipc_policer_t ind_entry;

   // Unmapped offsets and reserved bits read zero
   always_comb
   begin
      ind_entry = ind_valid ? pol_mem[ind_idx] : '0;
      nxt_rdata = rdata_ff;
      if (reg_rd_i)
      begin
         nxt_rdata = '0;
         case (reg_addr_i)
            pipc_pkg::ADDR_AUTH_CTL:
            begin
               nxt_rdata[pipc_pkg::ACL_EN_BIT] = acl_enable_i;
               nxt_rdata[1:0] = auth_mode_ff;
            end
            pipc_pkg::ADDR_POINTER:
            begin
               nxt_rdata[pipc_pkg::PORT_IDX_LSB +: 3] = port_idx_ff;
               nxt_rdata[1:0] = queue_ptr_ff;
            end
            pipc_pkg::ADDR_PRIO_MAP:
               for (int p = 0; p < 8; p++)
                  nxt_rdata[pipc_pkg::MAP_FIELD_W*p +: 2] = map_ff[2*p +: 2];
            pipc_pkg::ADDR_POLICE_CTL:
               nxt_rdata[11:0] = ctl_ff;
            pipc_pkg::ADDR_QUEUE_RATE:
               nxt_rdata = ind_entry[63:32];
            pipc_pkg::ADDR_QUEUE_BURST:
               nxt_rdata = ind_entry[31:0];
            pipc_pkg::ADDR_PM_THRESH:
            begin
               nxt_rdata[pipc_pkg::PM_MAX_LSB +: 11] = pm_max_ff;
               nxt_rdata[10:0] = pm_min_ff;
            end
            default:
               nxt_rdata = '0;
         endcase
      end
   end

   // Read data held until the next read
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdata_ff <= '0;
         rvalid_ff <= 1'b0;
      end
      else
      begin
         rdata_ff <= nxt_rdata;
         rvalid_ff <= reg_rd_i;
      end
   end

   assign reg_rdata_o = rdata_ff;
   assign reg_rvalid_o = rvalid_ff;

   // ****************************************************************
   // Control decode toward the datapath
   // ****************************************************************
   logic auth_en_c;
   logic trap_c;
   logic miss_block_c;
   logic miss_fwd_c;

   // Reserved mode 00 leaves every control inactive
   always_comb
   begin
      auth_en_c = 1'b0;
      trap_c = 1'b0;
      miss_block_c = 1'b0;
      miss_fwd_c = 1'b0;
      case (auth_mode_ff)
         pipc_pkg::AUTH_BLOCK:
         begin
            auth_en_c = 1'b1;
            miss_block_c = acl_enable_i;
         end
         pipc_pkg::AUTH_PASS:
            miss_fwd_c = acl_enable_i;
         pipc_pkg::AUTH_TRAP:
         begin
            auth_en_c = 1'b1;
            trap_c = 1'b1;
            miss_block_c = acl_enable_i;
         end
         default:
            auth_en_c = 1'b0;
      endcase
   end

   assign auth_enable_o = auth_en_c;
   assign trap_to_host_o = trap_c;
   assign acl_miss_block_o = miss_block_c;
   assign acl_miss_forward_o = miss_fwd_c;
   assign prio_queue_o = map_ff;
   // Fields carried as stored, datapath acts on them
   assign police_ctl_o = ctl_ff;
   assign wred_active_o = ctl_ff.police_en;
   // Reservation packets only droppable under active WRED
   assign srp_drop_allowed_o = ctl_ff.police_en && ctl_ff.srp_drop_allow;
   assign monitor_port_o = port_idx_ff;
   assign monitor_queue_o = queue_ptr_ff;
   assign pm_max_thresh_o = pm_max_ff;
   assign pm_min_thresh_o = pm_min_ff;

   // ****************************************************************
   // Policer lookup
   // ****************************************************************
   pipc_pkg::pipc_policer_t pol_cfg_ff;
   pipc_pkg::pipc_policer_t nxt_pol_cfg;
   logic [2:0] eff_port;

   // Queue-only policing shares the port 0 aggregate
   always_comb
   begin
      eff_port = ctl_ff.port_based ? pol_port_i : 3'h0;
      nxt_pol_cfg = '0;
      if (32'(eff_port) < NUM_PORTS)
         nxt_pol_cfg = pol_mem[{eff_port, pol_queue_i}];
   end

   // One cycle lookup latency
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
         pol_cfg_ff <= '0;
      else
         pol_cfg_ff <= nxt_pol_cfg;
   end

   assign pol_cfg_o = pol_cfg_ff;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n);

   sequence s_ptr_wr;
      reg_wr_i && reg_addr_i == pipc_pkg::ADDR_POINTER;
   endsequence

   sequence s_rate_wr;
      reg_wr_i && reg_addr_i == pipc_pkg::ADDR_QUEUE_RATE && ind_valid;
   endsequence

   sequence s_rate_rd;
      reg_rd_i && !reg_wr_i && reg_addr_i == pipc_pkg::ADDR_QUEUE_RATE;
   endsequence

   a_port_idx_load: assert property (s_ptr_wr |=>
      port_idx_ff == $past(reg_wdata_i[18:16]))
      else $error("port index not loaded");
   a_queue_ptr_load: assert property (s_ptr_wr |=>
      monitor_queue_o == $past(reg_wdata_i[1:0]))
      else $error("queue pointer not loaded");
   a_block_mode: assert property (auth_mode_ff == 2'h1 |->
      auth_enable_o && !trap_to_host_o && acl_miss_block_o == acl_enable_i)
      else $error("block mode decode wrong");
   a_pass_mode: assert property (auth_mode_ff == 2'h2 |->
      !auth_enable_o && acl_miss_forward_o == acl_enable_i)
      else $error("pass mode decode wrong");
   a_trap_mode: assert property (auth_mode_ff == 2'h3 |->
      trap_to_host_o && auth_enable_o && !acl_miss_forward_o)
      else $error("trap mode decode wrong");
   a_auth_byte_read: assert property (
      reg_rd_i && reg_addr_i == pipc_pkg::ADDR_AUTH_CTL |=>
      reg_rdata_o[31:3] == '0 && reg_rdata_o[2] == $past(acl_enable_i))
      else $error("auth byte read wrong");
   a_rate_roundtrip: assert property (
      s_rate_wr ##1 (s_rate_rd and (!$changed(port_idx_ff)
         && !$changed(queue_ptr_ff))) |=>
      reg_rdata_o == $past(reg_wdata_i, 2))
      else $error("rate entry not kept");
   a_pm_reserved: assert property (
      reg_rd_i && reg_addr_i == pipc_pkg::ADDR_PM_THRESH |=>
      reg_rdata_o[31:27] == '0 && reg_rdata_o[15:11] == '0)
      else $error("threshold reserved bits set");
   a_wred_gate: assert property (srp_drop_allowed_o |->
      wred_active_o && police_ctl_o.srp_drop_allow)
      else $error("reservation drop while off");
   a_aggregate_port: assert property (rst_n && !ctl_ff.port_based
      ##1 !ctl_ff.port_based && $stable(pol_queue_i) |->
      pol_cfg_o == $past(pol_mem[{3'h0, pol_queue_i}]))
      else $error("aggregate entry not used");

endmodule // pipc_port_ingress

/* testbench/tb_pipc_port_ingress.sv */
// Self-checking testbench for the ingress policing register bank
module tb_pipc_port_ingress;
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************************************
   // Signals and design instance
   // ****************************************************************
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [11:0] reg_addr_i = 12'h000;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [31:0] reg_wdata_i = 32'h0000_0000;
   logic [31:0] reg_rdata_o;
   logic reg_rvalid_o;
   logic acl_enable_i = 1'b0;
   logic auth_enable_o;
   logic trap_to_host_o;
   logic acl_miss_block_o;
   logic acl_miss_forward_o;
   logic [15:0] prio_queue_o;
   pipc_pkg::pipc_police_ctl_t police_ctl_o;
   logic wred_active_o;
   logic srp_drop_allowed_o;
   logic [2:0] monitor_port_o;
   logic [1:0] monitor_queue_o;
   logic [2:0] pol_port_i = 3'h0;
   logic [1:0] pol_queue_i = 2'h0;
   pipc_pkg::pipc_policer_t pol_cfg_o;
   logic [10:0] pm_max_thresh_o;
   logic [10:0] pm_min_thresh_o;
   int err_total = 0;
   int checks_done = 0;

   // 250 MHz clock
   always #2 clk_i = ~clk_i;

   pipc_port_ingress pipc_port_ingress_inst (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .reg_addr_i(reg_addr_i),
      .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i),
      .reg_wdata_i(reg_wdata_i),
      .reg_rdata_o(reg_rdata_o),
      .reg_rvalid_o(reg_rvalid_o),
      .acl_enable_i(acl_enable_i),
      .auth_enable_o(auth_enable_o),
      .trap_to_host_o(trap_to_host_o),
      .acl_miss_block_o(acl_miss_block_o),
      .acl_miss_forward_o(acl_miss_forward_o),
      .prio_queue_o(prio_queue_o),
      .police_ctl_o(police_ctl_o),
      .wred_active_o(wred_active_o),
      .srp_drop_allowed_o(srp_drop_allowed_o),
      .monitor_port_o(monitor_port_o),
      .monitor_queue_o(monitor_queue_o),
      .pol_port_i(pol_port_i),
      .pol_queue_i(pol_queue_i),
      .pol_cfg_o(pol_cfg_o),
      .pm_max_thresh_o(pm_max_thresh_o),
      .pm_min_thresh_o(pm_min_thresh_o)
   );

   // ****************************************************************
   // Access and compare tasks
   // ****************************************************************
   task automatic give_verdict();
      if (err_total == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      checks_done = checks_done + 1;
      if (got !== exp)
      begin
         err_total = err_total + 1;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Strobe held for exactly one edge, released right after it
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
      // Let the edge's updates settle before anyone looks
      #1;
   endtask

   // Read strobe already raised; drop it and wait for the answer
   task automatic end_rd(input logic [31:0] exp);
      int n;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      n = 0;
      #1;
      while (reg_rvalid_o !== 1'b1 && n < 4)
      begin
         @(posedge clk_i);
         #1;
         n++;
      end
      if (n == 4)
      begin
         err_total = err_total + 1;
         $display("Error at %0t: read answer missing", $time);
         give_verdict();
      end
      else
         check({32'h0, reg_rdata_o}, {32'h0, exp});
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      @(posedge clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      end_rd(exp);
   endtask

   // Pointer write immediately followed by an indirect read
   task automatic ptr_rdc(input logic [31:0] p, input logic [11:0] a,
                          input logic [31:0] exp);
      wr(pipc_pkg::ADDR_POINTER, p);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      end_rd(exp);
   endtask

   task automatic pol_chk(input logic [2:0] p, input logic [1:0] q,
                          input logic [63:0] exp);
      @(posedge clk_i);
      pol_port_i <= p;
      pol_queue_i <= q;
      @(posedge clk_i);
      #1;
      check(pol_cfg_o, exp);
   endtask

   // Distinct per-entry pattern so aliasing between entries shows up
   function automatic logic [31:0] rv(input int p, input int q);
      return 32'(32'hC000_0000 | (p << 20) | (q << 16) | (p << 4) | q);
   endfunction

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial
   begin
      logic [3:0] dec;
      logic [31:0] v;
      repeat (5) @(posedge clk_i);
      rst_b_i <= 1'b1;
      // Synchroniser needs two edges before the first access
      repeat (4) @(posedge clk_i);
      rdc(pipc_pkg::ADDR_AUTH_CTL, 32'h0000_0000);
      rdc(pipc_pkg::ADDR_POINTER, 32'h0000_0000);
      rdc(pipc_pkg::ADDR_PRIO_MAP, 32'h3322_1100);
      check(64'(prio_queue_o), 64'hFA50);
      rdc(pipc_pkg::ADDR_POLICE_CTL, 32'h0000_0020);
      rdc(pipc_pkg::ADDR_QUEUE_RATE, 32'h1000_2000);
      rdc(pipc_pkg::ADDR_QUEUE_BURST, 32'h1000_3000);
      rdc(pipc_pkg::ADDR_PM_THRESH, 32'h0400_0080);
      pol_chk(3'h6, 2'h3, 64'h1000_2000_1000_3000);
      // All modes against both access-list states
      for (int m = 0; m < 4; m++)
         for (int a = 0; a < 2; a++)
         begin
            @(posedge clk_i);
            acl_enable_i <= a[0];
            wr(pipc_pkg::ADDR_AUTH_CTL, 32'hFFFF_FFFC | 32'(m));
            #1;
            dec[3] = (m == 1 || m == 3);
            dec[2] = (m == 3);
            dec[1] = a[0] && (m == 1 || m == 3);
            dec[0] = a[0] && (m == 2);
            check(64'({auth_enable_o, trap_to_host_o, acl_miss_block_o,
                       acl_miss_forward_o}), 64'(dec));
            rdc(pipc_pkg::ADDR_AUTH_CTL, 32'({a[0], m[1:0]}));
         end
      // Pointer fields and reserved bits
      wr(pipc_pkg::ADDR_POINTER, 32'hFFFF_FFFF);
      rdc(pipc_pkg::ADDR_POINTER, 32'h0007_0003);
      check(64'({monitor_port_o, monitor_queue_o}), 64'h1F);
      // Port index 7 has no storage behind it
      wr(pipc_pkg::ADDR_QUEUE_RATE, 32'h1234_5678);
      rdc(pipc_pkg::ADDR_QUEUE_RATE, 32'h0000_0000);
      wr(pipc_pkg::ADDR_PRIO_MAP, 32'hFFFF_FFFF);
      rdc(pipc_pkg::ADDR_PRIO_MAP, 32'h3333_3333);
      check(64'(prio_queue_o), 64'hFFFF);
      wr(pipc_pkg::ADDR_PRIO_MAP, 32'hC48C_2064);
      check(64'(prio_queue_o), 64'h0088);
      // Walk each police control bit, then a combined pattern
      for (int b = 0; b <= 12; b++)
      begin
         v = (b == 12) ? 32'hFFFF_F005 : (32'h1 << b);
         wr(pipc_pkg::ADDR_POLICE_CTL, v);
         rdc(pipc_pkg::ADDR_POLICE_CTL, v & 32'h0000_0FFF);
         check(64'(police_ctl_o), 64'(v[11:0]));
         check(64'({wred_active_o, srp_drop_allowed_o}),
               64'({v[0], v[0] & v[2]}));
      end
      // Per-port policing: fill every entry, then read and look up
      wr(pipc_pkg::ADDR_POLICE_CTL, 32'h0000_0081);
      for (int p = 0; p < 7; p++)
         for (int q = 0; q < 4; q++)
         begin
            wr(pipc_pkg::ADDR_POINTER, 32'((p << 16) | q));
            wr(pipc_pkg::ADDR_QUEUE_RATE, rv(p, q));
            wr(pipc_pkg::ADDR_QUEUE_BURST, ~rv(p, q));
         end
      for (int p = 0; p < 7; p++)
         for (int q = 0; q < 4; q++)
         begin
            ptr_rdc(32'((p << 16) | q), pipc_pkg::ADDR_QUEUE_RATE, rv(p, q));
            rdc(pipc_pkg::ADDR_QUEUE_BURST, ~rv(p, q));
            pol_chk(p[2:0], q[1:0], {rv(p, q), ~rv(p, q)});
         end
      pol_chk(3'h7, 2'h1, 64'h0);
      // Rate write read straight back, pointer left alone
      wr(pipc_pkg::ADDR_QUEUE_RATE, 32'h5AA5_C33C);
      reg_rd_i <= 1'b1;
      reg_addr_i <= pipc_pkg::ADDR_QUEUE_RATE;
      end_rd(32'h5AA5_C33C);
      // Per-queue policing uses port index 0 for every port
      wr(pipc_pkg::ADDR_POLICE_CTL, 32'h0000_0001);
      pol_chk(3'h5, 2'h2, {rv(0, 2), ~rv(0, 2)});
      // Thresholds and their reserved bits
      wr(pipc_pkg::ADDR_PM_THRESH, 32'hFFFF_FFFF);
      rdc(pipc_pkg::ADDR_PM_THRESH, 32'h07FF_07FF);
      wr(pipc_pkg::ADDR_PM_THRESH, 32'h0123_0456);
      check(64'({pm_max_thresh_o, pm_min_thresh_o}),
            64'({11'h123, 11'h456}));
      // Unmapped offset reads zero and ignores writes
      wr(12'h810, 32'hFFFF_FFFF);
      rdc(12'h810, 32'h0000_0000);
      give_verdict();
   end

endmodule // tb_pipc_port_ingress
